// File: inc/frame_link_cfg.svh
// offsets, field positions, command codes and line patterns of the frame link
`ifndef FRAME_LINK_CFG_SVH
`define FRAME_LINK_CFG_SVH
// ************************************************************
// register indices (write side)
// ************************************************************
`define REG_COMMAND 3'h0
`define REG_INT_CTRL 3'h1
`define REG_VECTOR 3'h2
`define REG_RX_CFG 3'h3
`define REG_MODE_CFG 3'h4
`define REG_TX_CTRL 3'h5
`define REG_STATION 3'h6
`define REG_TX_DATA 3'h7
// ************************************************************
// register indices (read side)
// ************************************************************
`define REG_STATUS 3'h0
`define REG_SPECIAL 3'h1
`define REG_RX_DATA 3'h3
// ************************************************************
// field positions
// ************************************************************
`define IC_EXT_EN 0
`define IC_TX_EN 1
`define IC_SAV 2
`define RC_RX_EN 0
`define RC_ADDR_SEARCH 2
`define RC_AUTO_EN 5
`define MC_FRAME_MODE 5
`define TC_RTS 1
`define TC_TX_EN 3
`define TC_DTR 7
// ************************************************************
// command codes in bits 5:3, latch reset in bits 7:6
// ************************************************************
`define CMD_SEND_ABORT 3'h1
`define CMD_RESET_EXT 3'h2
`define CMD_CHAN_RESET 3'h3
`define CMD_RESET_TX_INT 3'h5
`define CMD_ERROR_RESET 3'h6
`define CMD_RESET_UNDERRUN 2'h3
// ************************************************************
// line patterns and counts
// ************************************************************
`define FLAG_OCTET 16'h007E
`define ABORT_OCTET 16'h00FF
`define GLOBAL_ADDR 8'hFF
`define CRC_PRESET 16'hFFFF
`define CRC_POLY_REFL 16'h8408
`define CRC_RESIDUE 16'hF0B8
`define ONES_STUFF 4'h5
`define ONES_FLAG 4'h6
`define ONES_IDLE 4'hE
`define MIN_FRAME_OCTETS 3'h4
`define RX_DELAY_BITS 3'h6
`define VEC_CAUSE_TX 3'h4
`define VEC_CAUSE_EXT 3'h5
`define VEC_CAUSE_RX 3'h6
`define VEC_CAUSE_SPECIAL 3'h7
`endif

// File: inc/frame_link_pkg.sv
// types shared by the frame link modules
package frame_link_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic carrier_detect_in;
		logic clear_to_send;
	} modem_in_t;

	typedef struct packed {
		logic data_terminal_ready;
		logic request_to_send;
	} modem_out_t;

	typedef enum logic [4:0] {
		TX_OFF = 5'h01,
		TX_FLAG = 5'h02,
		TX_DATA = 5'h04,
		TX_FCS = 5'h08,
		TX_ABORT = 5'h10
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_HUNT = 3'h1,
		RX_FRAME = 3'h2,
		RX_DROP = 3'h4
	} rx_state_t;

	typedef struct packed {
		logic [3:0] cnt;
	} run_state_t;

	typedef struct packed {
		logic [15:0] crc;
	} crc_state_t;
endpackage

// File: rtl/ones_run_counter.sv
// saturating counter of consecutive one bits on a serial stream
`timescale 1ns/10ps
module ones_run_counter (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// bit stream
	input wire logic clear_i,
	input wire logic step_i,
	input wire logic bit_i,
	// run length
	output logic [3:0] count_o
);
	import frame_link_pkg::*;

	run_state_t q;
	run_state_t d;

	always_comb begin
		d = q;
		if (clear_i) begin
			d.cnt = 4'h0;
		end else if (step_i) begin
			if (!bit_i) begin
				d.cnt = 4'h0;
			end else if (q.cnt != 4'hF) begin
				d.cnt = q.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign count_o = q.cnt;
endmodule

// File: rtl/crc16_serial.sv
// bit-serial frame check, low bit first, preset to all ones
`timescale 1ns/10ps
`include "frame_link_cfg.svh"
module crc16_serial (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// bit stream
	input wire logic init_i,
	input wire logic step_i,
	input wire logic bit_i,
	// running value
	output logic [15:0] crc_o
);
	import frame_link_pkg::*;

	crc_state_t q;
	crc_state_t d;

	always_comb begin
		d = q;
		if (init_i) begin
			d.crc = `CRC_PRESET;
		end else if (step_i) begin
			d.crc = {1'b0, q.crc[15:1]} ^ ((q.crc[0] ^ bit_i) ? `CRC_POLY_REFL : 16'h0000);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q.crc <= `CRC_PRESET;
		end else begin
			q <= d;
		end
	end

	assign crc_o = q.crc;
endmodule

// File: rtl/frame_link.sv
// one bit-oriented framing channel: registers, transmitter and receiver
// ************************************************************
// Summary of operation
// - flag is zero, six ones, zero
// - transmitter inserts zero after five ones
// - receiver deletes zero after five ones
// - seven to fourteen ones mean abort
// - fifteen or more ones mean idle
// - no stuffing on flag, abort, idle
// - sixteen-bit CCITT check generated and checked
// - one control octet after address, then check
// - receiver ignores line until a flag
// - address search enable is receive config bit 2
// - searching keeps own or global address only
// - auto enable gates transmitter and receiver
// - external interrupt on modem, underrun, abort change
// - interrupt control bit 2 modifies vector
// - transmit control bits drive modem outputs
// - enabled idle transmitter sends back-to-back flags
// - receive shared-zero flags, transmit separate flags
// ************************************************************
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "frame_link_cfg.svh"
module frame_link (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register port
	input frame_link_pkg::reg_req_t req_i,
	output logic [7:0] rdata_o,
	// serial line, one bit per clock
	input wire logic rx_data_i,
	output logic tx_data_o,
	// modem control
	input frame_link_pkg::modem_in_t modem_i,
	output frame_link_pkg::modem_out_t modem_o,
	// interrupt request
	output logic int_o
);
	import frame_link_pkg::*;

	typedef struct packed {
		logic [7:0] int_ctrl;
		logic [7:0] vector;
		logic [7:0] rx_cfg;
		logic [7:0] mode_cfg;
		logic [7:0] tx_ctrl;
		logic [7:0] station;
		tx_state_t tx_st;
		logic [15:0] tx_sh;
		logic [3:0] tx_cnt;
		logic [7:0] tx_buf;
		logic tx_full;
		logic tx_int;
		logic tx_bit;
		logic underrun;
		rx_state_t rx_st;
		logic [5:0] dly;
		logic [2:0] dly_n;
		logic [7:0] rx_sh;
		logic [2:0] rx_cnt;
		logic [2:0] oct_n;
		logic [7:0] rx_buf;
		logic rx_avail;
		logic eof;
		logic crc_err;
		logic abort_det;
		logic idle_det;
		logic cd_prev;
		logic cts_prev;
		logic ext_pend;
		logic irq;
		logic [7:0] rdata;
	} link_state_t;

	link_state_t q;
	link_state_t d;

	logic [3:0] tx_ones;
	logic [3:0] rx_ones;
	logic [15:0] tx_crc;
	logic [15:0] rx_crc;
	logic tx_en;
	logic rx_en;
	logic cmd_wr;
	logic [2:0] cmd;
	logic tx_sending;
	logic tx_stuff;
	logic tx_crc_init;
	logic tx_crc_step;
	logic rx_pop;
	logic rx_crc_init;
	logic [7:0] rx_byte;
	logic [2:0] cause;

	// ************************************************************
	// enables and command decode
	// ************************************************************
	always_comb begin
		tx_en = q.tx_ctrl[`TC_TX_EN] && q.mode_cfg[`MC_FRAME_MODE]
			&& (!q.rx_cfg[`RC_AUTO_EN] || modem_i.clear_to_send);
		rx_en = q.rx_cfg[`RC_RX_EN] && q.mode_cfg[`MC_FRAME_MODE]
			&& (!q.rx_cfg[`RC_AUTO_EN] || modem_i.carrier_detect_in);
		cmd_wr = req_i.wr && (req_i.addr == `REG_COMMAND);
		cmd = req_i.wdata[5:3];
		tx_sending = (q.tx_st == TX_DATA) || (q.tx_st == TX_FCS);
		tx_stuff = tx_sending && (tx_ones == `ONES_STUFF);
		tx_crc_init = (q.tx_st == TX_FLAG) && (q.tx_cnt == 4'h7) && q.tx_full && tx_en;
		tx_crc_step = (q.tx_st == TX_DATA) && !tx_stuff;
		rx_crc_init = rx_en && !rx_data_i && (rx_ones == `ONES_FLAG);
		// a one after five ones is flag or abort, never frame content
		rx_pop = rx_en && (q.rx_st != RX_HUNT) && (rx_ones < `ONES_STUFF)
			&& (q.dly_n == `RX_DELAY_BITS);
		rx_byte = {q.dly[0], q.rx_sh[7:1]};
	end

	// ************************************************************
	// shared helpers
	// ************************************************************
	ones_run_counter u_tx_run (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.clear_i(!tx_sending || tx_stuff), .step_i(tx_sending), .bit_i(q.tx_sh[0]),
		.count_o(tx_ones));
	ones_run_counter u_rx_run (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.clear_i(!rx_en), .step_i(rx_en), .bit_i(rx_data_i), .count_o(rx_ones));
	crc16_serial u_tx_crc (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.init_i(tx_crc_init), .step_i(tx_crc_step), .bit_i(q.tx_sh[0]), .crc_o(tx_crc));
	crc16_serial u_rx_crc (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.init_i(rx_crc_init), .step_i(rx_pop), .bit_i(q.dly[0]), .crc_o(rx_crc));

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d = q;
		// register writes
		if (req_i.wr) begin
			unique case (req_i.addr)
				`REG_INT_CTRL: d.int_ctrl = req_i.wdata;
				`REG_VECTOR: d.vector = req_i.wdata;
				`REG_RX_CFG: d.rx_cfg = req_i.wdata;
				`REG_MODE_CFG: d.mode_cfg = req_i.wdata;
				`REG_TX_CTRL: d.tx_ctrl = req_i.wdata;
				`REG_STATION: d.station = req_i.wdata;
				`REG_TX_DATA: begin
					d.tx_buf = req_i.wdata;
					d.tx_full = 1'b1;
					d.tx_int = 1'b0;
				end
				default: d.int_ctrl = q.int_ctrl;
			endcase
		end
		if (cmd_wr && (cmd == `CMD_RESET_EXT)) begin
			d.ext_pend = 1'b0;
		end
		if (cmd_wr && (cmd == `CMD_RESET_TX_INT)) begin
			d.tx_int = 1'b0;
		end
		if (cmd_wr && (cmd == `CMD_ERROR_RESET)) begin
			d.eof = 1'b0;
			d.crc_err = 1'b0;
		end
		if (cmd_wr && (req_i.wdata[7:6] == `CMD_RESET_UNDERRUN)) begin
			d.underrun = 1'b0;
		end
		if (req_i.rd && (req_i.addr == `REG_RX_DATA)) begin
			d.rx_avail = 1'b0;
		end

		// transmitter
		d.tx_bit = 1'b1;
		unique case (q.tx_st)
			TX_OFF: begin
				if (tx_en) begin
					d.tx_st = TX_FLAG;
					d.tx_sh = `FLAG_OCTET;
					d.tx_cnt = 4'h0;
				end
			end
			TX_FLAG, TX_ABORT: begin
				d.tx_bit = q.tx_sh[0];
				d.tx_sh = {1'b0, q.tx_sh[15:1]};
				d.tx_cnt = q.tx_cnt + 4'h1;
				if (q.tx_cnt == 4'h7) begin
					d.tx_cnt = 4'h0;
					d.tx_sh = `FLAG_OCTET;
					d.tx_st = TX_FLAG;
					if (!tx_en) begin
						d.tx_st = TX_OFF;
					end else if (q.tx_full && (q.tx_st == TX_FLAG)) begin
						d.tx_st = TX_DATA;
						d.tx_sh = {8'h00, q.tx_buf};
						d.tx_full = 1'b0;
						d.tx_int = 1'b1;
					end
				end
			end
			TX_DATA, TX_FCS: begin
				if (tx_stuff) begin
					d.tx_bit = 1'b0;
				end else begin
					d.tx_bit = q.tx_sh[0];
					d.tx_sh = {1'b0, q.tx_sh[15:1]};
					d.tx_cnt = q.tx_cnt + 4'h1;
					if ((q.tx_st == TX_DATA) && (q.tx_cnt == 4'h7)) begin
						d.tx_cnt = 4'h0;
						if (q.tx_full) begin
							d.tx_sh = {8'h00, q.tx_buf};
							d.tx_full = 1'b0;
							d.tx_int = 1'b1;
						end else begin
							// underrun closes the frame with its check
							d.tx_st = TX_FCS;
							d.tx_sh = ~(({1'b0, tx_crc[15:1]})
								^ ((tx_crc[0] ^ q.tx_sh[0]) ? `CRC_POLY_REFL : 16'h0000));
							d.underrun = 1'b1;
						end
					end else if ((q.tx_st == TX_FCS) && (q.tx_cnt == 4'hF)) begin
						d.tx_st = TX_FLAG;
						d.tx_sh = `FLAG_OCTET;
						d.tx_cnt = 4'h0;
					end
				end
				if (cmd_wr && (cmd == `CMD_SEND_ABORT)) begin
					d.tx_st = TX_ABORT;
					d.tx_sh = `ABORT_OCTET;
					d.tx_cnt = 4'h0;
				end
				if (!tx_en) begin
					d.tx_st = TX_OFF;
				end
			end
			default: begin
				d.tx_st = TX_OFF;
			end
		endcase

		// receiver line conditions
		if (!rx_en) begin
			d.rx_st = RX_HUNT;
			d.abort_det = 1'b0;
			d.idle_det = 1'b0;
		end else if (rx_data_i) begin
			if (rx_ones == `ONES_FLAG) begin
				d.abort_det = 1'b1;
				d.rx_st = RX_HUNT;
			end
			if (rx_ones == `ONES_IDLE) begin
				d.idle_det = 1'b1;
			end
		end else if (rx_ones == `ONES_FLAG) begin
			// closing flag may be the next opening flag
			if ((q.rx_st == RX_FRAME) && (q.oct_n >= `MIN_FRAME_OCTETS)
				&& (q.rx_cnt == 3'h0)) begin
				d.eof = 1'b1;
				d.crc_err = d.crc_err || (rx_crc != `CRC_RESIDUE);
			end
			d.rx_st = RX_FRAME;
			d.dly_n = 3'h0;
			d.rx_cnt = 3'h0;
			d.oct_n = 3'h0;
		end else begin
			d.abort_det = 1'b0;
			d.idle_det = 1'b0;
		end

		// receiver data path; delay hides the closing flag's bits
		if (rx_en && (q.rx_st != RX_HUNT) && !(!rx_data_i && (rx_ones >= `ONES_STUFF))) begin
			if (!(rx_data_i && (rx_ones >= `ONES_FLAG))) begin
				d.dly = {rx_data_i, q.dly[5:1]};
				if (q.dly_n != `RX_DELAY_BITS) begin
					d.dly_n = q.dly_n + 3'h1;
				end
			end
		end
		if (rx_pop) begin
			d.rx_sh = rx_byte;
			d.rx_cnt = q.rx_cnt + 3'h1;
			if (q.rx_cnt == 3'h7) begin
				if ((q.oct_n == 3'h0) && q.rx_cfg[`RC_ADDR_SEARCH]
					&& (rx_byte != q.station) && (rx_byte != `GLOBAL_ADDR)) begin
					d.rx_st = RX_DROP;
				end else if (q.rx_st == RX_FRAME) begin
					d.rx_buf = rx_byte;
					d.rx_avail = 1'b1;
				end
				if (q.oct_n != 3'h7) begin
					d.oct_n = q.oct_n + 3'h1;
				end
			end
		end

		// external status changes, set wins over clear
		d.cd_prev = modem_i.carrier_detect_in;
		d.cts_prev = modem_i.clear_to_send;
		if ((modem_i.carrier_detect_in != q.cd_prev) || (modem_i.clear_to_send != q.cts_prev)
			|| (d.underrun && !q.underrun) || (d.abort_det != q.abort_det)
			|| (d.idle_det != q.idle_det)) begin
			d.ext_pend = 1'b1;
		end

		// interrupt request and vector cause
		cause = `VEC_CAUSE_TX;
		if ((q.eof || q.crc_err) && (q.int_ctrl[4:3] != 2'h0)) begin
			cause = `VEC_CAUSE_SPECIAL;
		end else if (q.rx_avail && (q.int_ctrl[4:3] != 2'h0)) begin
			cause = `VEC_CAUSE_RX;
		end else if (q.ext_pend && q.int_ctrl[`IC_EXT_EN]) begin
			cause = `VEC_CAUSE_EXT;
		end
		d.irq = (q.ext_pend && q.int_ctrl[`IC_EXT_EN])
			|| (q.tx_int && q.int_ctrl[`IC_TX_EN])
			|| ((q.rx_avail || q.eof || q.crc_err) && (q.int_ctrl[4:3] != 2'h0));

		// read data, one cycle after the strobe
		d.rdata = 8'h00;
		if (req_i.rd) begin
			unique case (req_i.addr)
				`REG_STATUS: d.rdata = {q.abort_det, q.underrun, modem_i.clear_to_send, q.idle_det,
					modem_i.carrier_detect_in, !q.tx_full, q.irq, q.rx_avail};
				`REG_SPECIAL: d.rdata = {q.eof, q.crc_err, 6'h00};
				`REG_VECTOR: d.rdata = q.int_ctrl[`IC_SAV] ?
					{q.vector[7:4], cause, q.vector[0]} : q.vector;
				`REG_RX_DATA: d.rdata = q.rx_buf;
				default: d.rdata = 8'h00;
			endcase
		end

		if (cmd_wr && (cmd == `CMD_CHAN_RESET)) begin
			d = '0;
			d.tx_st = TX_OFF;
			d.rx_st = RX_HUNT;
			d.tx_bit = 1'b1;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.tx_st <= TX_OFF;
			q.rx_st <= RX_HUNT;
			q.tx_bit <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rdata_o = q.rdata;
	assign tx_data_o = q.tx_bit;
	assign modem_o.data_terminal_ready = q.tx_ctrl[`TC_DTR];
	assign modem_o.request_to_send = q.tx_ctrl[`TC_RTS];
	assign int_o = q.irq;
endmodule

// File: bench/frame_link_checker.sv
// port-level assertions of the frame link
`timescale 1ns/10ps
module frame_link_checker
	import frame_link_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// register port
	input frame_link_pkg::reg_req_t req_i,
	input wire logic [7:0] rdata_o,
	// line, modem and interrupt
	input wire logic rx_data_i,
	input wire logic tx_data_o,
	input frame_link_pkg::modem_in_t modem_i,
	input frame_link_pkg::modem_out_t modem_o,
	input wire logic int_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic wr5;
	assign wr5 = req_i.wr && req_i.addr == 3'h5;
	sequence flag_s;
		!tx_data_o ##1 tx_data_o [*6] ##1 !tx_data_o;
	endsequence
	sequence chan_rst_s;
		req_i.wr && req_i.addr == 3'h0 && req_i.wdata == 8'h18;
	endsequence
	rd_idle_a: assert property (!req_i.rd |=> rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	unmapped_rd_a: assert property (req_i.rd && req_i.addr[2] |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	dtr_follow_a: assert property (
		wr5 |=> modem_o.data_terminal_ready == $past(req_i.wdata[7]))
		else $error("dtr not following bit 7");
	rts_follow_a: assert property (
		wr5 |=> modem_o.request_to_send == $past(req_i.wdata[1]))
		else $error("rts not following bit 1");
	modem_hold_a: assert property (
		!(req_i.wr && (req_i.addr == 3'h5 || req_i.addr == 3'h0)) |=> $stable(modem_o))
		else $error("modem outputs moved without write");
	sep_flags_a: assert property (
		flag_s |=> not (tx_data_o [*6] ##1 !tx_data_o))
		else $error("transmitted flags share a zero");
	chan_reset_a: assert property (
		chan_rst_s |=> modem_o == 2'b00 && !int_o)
		else $error("channel reset left outputs active");
	tx_quiet_a: assert property (
		chan_rst_s |=> tx_data_o [*2])
		else $error("line not idle after channel reset");
endmodule

bind frame_link frame_link_checker u_frame_link_checker (
	.core_clk_i(core_clk_i),
	.rst_i(rst_i),
	.req_i(req_i),
	.rdata_o(rdata_o),
	.rx_data_i(rx_data_i),
	.tx_data_o(tx_data_o),
	.modem_i(modem_i),
	.modem_o(modem_o),
	.int_o(int_o)
);

// File: bench/remote_station.sv
// remote station: drives the receive line, decodes the transmit line
`timescale 1ns/10ps
module remote_station (
	// clock
	input wire logic core_clk_i,
	// serial line
	input wire logic line_i,
	output logic line_o
);
	logic [7:0] got_q[$];
	logic [7:0] sr = 8'h00;
	logic in_frame = 1'b0;
	int flags = 0;
	int run_q = 0;
	int ones = 0;
	int nb = 0;
	initial line_o = 1'b1;
	task automatic put(input logic b);
		@(posedge core_clk_i);
		line_o <= b;
	endtask
	// flags and aborts go out unstuffed
	task automatic send_raw(input logic [7:0] v);
		for (int i = 0; i < 8; i++) put(v[i]);
		run_q = 0;
	endtask
	task automatic send_octet(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			put(v[i]);
			run_q = v[i] ? run_q + 1 : 0;
			if (run_q == 5) begin
				put(1'b0);
				run_q = 0;
			end
		end
	endtask
	always @(posedge core_clk_i) begin
		if (line_i === 1'b1) begin
			ones++;
			sr = {1'b1, sr[7:1]};
			nb++;
		end else begin
			if (ones == 6) begin
				flags++;
				in_frame = 1'b1;
				nb = 0;
			end else if (ones > 6) begin
				in_frame = 1'b0;
			end else if (ones != 5) begin
				sr = {1'b0, sr[7:1]};
				nb++;
			end
			ones = 0;
		end
		if (nb == 8) begin
			if (in_frame) got_q.push_back(sr);
			nb = 0;
		end
	end
endmodule

// File: bench/tb_top.sv
// self-checking bench of the frame link
`timescale 1ns/10ps
module tb_top;
	import frame_link_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	reg_req_t req_i = '0;
	logic [7:0] rdata_o;
	logic rx_data_i;
	logic tx_data_o;
	modem_in_t modem_i = 2'b11;
	modem_out_t modem_o;
	logic int_o;
	int bad_count = 0;
	int comparisons = 0;
	frame_link u_frame_link (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i),
		.rdata_o(rdata_o), .rx_data_i(rx_data_i), .tx_data_o(tx_data_o),
		.modem_i(modem_i), .modem_o(modem_o), .int_o(int_o));
	remote_station u_remote_station (.core_clk_i(core_clk_i), .line_i(tx_data_o),
		.line_o(rx_data_i));
	initial forever #25 core_clk_i = ~core_clk_i;
	// ****
	// helpers
	// ****
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_i);
		req_i <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_i);
		req_i <= '0;
		#1 d = rdata_o;
	endtask
	function automatic logic [15:0] fcs(input logic [7:0] b[$]);
		logic [15:0] c = 16'hFFFF;
		foreach (b[i]) for (int k = 0; k < 8; k++) c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		return ~c;
	endfunction
	task automatic send_frame(input logic [7:0] b[$]);
		logic [15:0] f = fcs(b);
		u_remote_station.send_raw(8'h7E);
		foreach (b[i]) u_remote_station.send_octet(b[i]);
		u_remote_station.send_octet(f[7:0]);
		u_remote_station.send_octet(f[15:8]);
		u_remote_station.send_raw(8'h7E);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		logic [7:0] d;
		wr(3'h5, 8'h82);
		@(posedge core_clk_i);
		check(modem_o, 2'b11);
		wr(3'h5, 8'h02);
		@(posedge core_clk_i);
		check(modem_o, 2'b01);
		rd(3'h6, d);
		check(d, 8'h00);
		wr(3'h2, 8'hA5);
		wr(3'h1, 8'h00);
		rd(3'h2, d);
		check(d, 8'hA5);
		wr(3'h1, 8'h04);
		rd(3'h2, d);
		check(d, 8'hA9);
		wr(3'h1, 8'h00);
	endtask
	task automatic t_tx();
		int n = 0;
		wr(3'h5, 8'h8A);
		repeat (40) @(posedge core_clk_i);
		check(u_remote_station.flags > 3, 1'b1);
		u_remote_station.got_q.delete();
		wr(3'h7, 8'hFF);
		while (u_remote_station.got_q.size() < 3 && n < 200) begin
			@(posedge core_clk_i);
			n++;
		end
		check(u_remote_station.got_q[0], 8'hFF);
		check({u_remote_station.got_q[2], u_remote_station.got_q[1]}, fcs('{8'hFF}));
	endtask
	task automatic t_auto();
		int n;
		wr(3'h3, 8'h20);
		modem_i.clear_to_send <= 1'b0;
		repeat (30) @(posedge core_clk_i);
		n = u_remote_station.flags;
		repeat (30) @(posedge core_clk_i);
		check(u_remote_station.flags, n);
		modem_i <= 2'b11;
		repeat (30) @(posedge core_clk_i);
		check(u_remote_station.flags > n, 1'b1);
	endtask
	task automatic t_rx();
		logic [7:0] d;
		logic [7:0] s;
		logic [15:0] f = fcs('{8'h42, 8'h7F});
		logic [7:0] e[$] = '{8'h42, 8'h7F, f[7:0], f[15:8]};
		int n;
		wr(3'h6, 8'h42);
		wr(3'h3, 8'h05);
		fork
			begin
				u_remote_station.send_raw(8'h00);
				send_frame('{8'h13, 8'h55});
				send_frame('{8'h42, 8'h7F});
			end
			foreach (e[i]) begin
				n = 0;
				do begin
					rd(3'h0, s);
					n++;
				end while (s[0] !== 1'b1 && n < 100);
				rd(3'h3, d);
				check(d, e[i]);
			end
		join
		repeat (20) @(posedge core_clk_i);
		rd(3'h1, d);
		check(d[7:6], 2'b10);
		u_remote_station.send_raw(8'hFF);
		rd(3'h0, d);
		check({d[7], d[4]}, 2'b10);
		repeat (20) @(posedge core_clk_i);
		rd(3'h0, d);
		check(d[4], 1'b1);
		wr(3'h1, 8'h05);
		rd(3'h2, d);
		check(d, 8'hAB);
		check(int_o, 1'b1);
		wr(3'h0, 8'h10);
		repeat (2) @(posedge core_clk_i);
		check(int_o, 1'b0);
		wr(3'h3, 8'h21);
		modem_i.carrier_detect_in <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		rd(3'h0, d);
		check(d[4:3], 2'b00);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		wr(3'h0, 8'h18);
		wr(3'h4, 8'h20);
		t_regs();
		t_tx();
		t_auto();
		t_rx();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		test_done();
	end
endmodule
